/* testbench.sv */
// Self-checking bench for tmr_core over APB.
// Assumes the bound checker and the pin model are compiled alongside.
`timescale 1ns/1ps
module testbench;
  localparam logic [11:0] A_ST = {tmr_pkg::IDX_STATUS, 2'b00};
  localparam logic [11:0] A_CH = {tmr_pkg::IDX_CNTH, 2'b00};
  localparam logic [11:0] A_CL = {tmr_pkg::IDX_CNTL, 2'b00};
  localparam logic [11:0] A_LH = {tmr_pkg::IDX_LIMH, 2'b00};
  localparam logic [11:0] A_LL = {tmr_pkg::IDX_LIML, 2'b00};
  localparam logic [11:0] A_C1 = {tmr_pkg::IDX_CH1CTL, 2'b00};
  logic        pclk, presetn, psel, penable, pwrite, go, lvl, err;
  logic        pready, pslverr, ext_clk, pin, busy, pin_out, pin_oe, wrap_irq, chan_irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [15:0] c1;
  logic [7:0]  edges, d;
  int          mismatches, n_checks, i;
  tmr_core DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_count_clock(ext_clk), .chan_pin_in(pin),
    .chan_pin_out(pin_out), .chan_pin_oe(pin_oe), .wrap_irq(wrap_irq), .chan_irq(chan_irq));
  tmr_pin_model u_pins (.pclk(pclk), .go(go), .edges(edges), .lvl(lvl),
    .ext_clk(ext_clk), .pin(pin), .busy(busy));
  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // Waits for the answer however long it takes; only the watchdog ends a hang
    do begin @(posedge pclk); end while (pready !== 1'b1);
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [11:0] a); apb(1'b0, a, 32'h0000_0000); endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] v); apb(1'b1, a, {24'h0, v}); endtask
  task automatic rdcnt();
    rd(A_CH); c1[15:8] = rdv[7:0];
    rd(A_CL); c1[7:0] = rdv[7:0];
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Clock, watchdog, tests
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  initial begin
    #100000;
    mismatches++;
    summarize();
  end
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
    pwdata = 32'h0000_0000; go = 1'b0; lvl = 1'b0; edges = 8'h0A;
    mismatches = 0; n_checks = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(A_ST); chk(rdv[15:0], 16'h0020);
    rd(A_LH); chk(rdv[15:0], 16'h00FF);
    rd(A_LL); chk(rdv[15:0], 16'h00FF);
    rd(A_C1); chk(rdv[15:0], 16'h0000);
    repeat (20) @(posedge pclk);
    rdcnt(); chk(c1, 16'h0000);
    rd(12'h3FC); chk({15'h0, err}, 16'h0001);
    rd(12'h101); chk({15'h0, err}, 16'h0001);
    $display("reset test done");
    for (i = 0; i < 7; i++) begin
      wr(A_ST, 8'h30);
      wr(A_ST, {5'h00, i[2:0]});
      repeat (512) @(posedge pclk);
      wr(A_ST, {5'h04, i[2:0]});
      rdcnt(); chk({15'h0, c1 > (514 >> i) - 3 && c1 < (514 >> i) + 3}, 16'h0001);
    end
    wr(A_ST, 8'h30);
    rdcnt(); chk(c1, 16'h0000);
    rd(A_ST); chk(rdv[15:0], 16'h0020);
    rd(A_LL); chk(rdv[15:0], 16'h00FF);
    $display("divider and clear test done");
    wr(A_ST, 8'h00);
    rd(A_CH);
    repeat (40) @(posedge pclk);
    rd(A_CH);
    wr(A_ST, 8'h20);
    rd(A_CL); d = rdv[7:0];
    rd(A_CL); d = rdv[7:0] - d;
    chk({15'h0, d > 8'd40 && d < 8'd80}, 16'h0001);
    $display("latch test done");
    wr(A_ST, 8'h30);
    wr(A_LH, 8'h00);
    wr(A_LL, 8'h0F);
    wr(A_ST, 8'h40);
    repeat (20) @(posedge pclk);
    wr(A_ST, 8'h60);
    rd(A_ST); chk(rdv[15:0], 16'h00E0);
    chk({15'h0, wrap_irq}, 16'h0001);
    rdcnt(); chk({15'h0, c1 <= 16'h000F}, 16'h0001);
    wr(A_ST, 8'hE0);
    rd(A_ST); chk(rdv[15:0], 16'h00E0);
    wr(A_ST, 8'h20);
    rd(A_ST); chk(rdv[15:0], 16'h0020);
    wr(A_LH, 8'h00);
    wr(A_ST, 8'h00);
    repeat (60) @(posedge pclk);
    wr(A_ST, 8'h20);
    rd(A_ST); chk(rdv[15:0], 16'h0020);
    wr(A_LL, 8'h0F);
    wr(A_ST, 8'h00);
    repeat (40) @(posedge pclk);
    wr(A_ST, 8'h20);
    rd(A_ST); chk(rdv[15:0], 16'h00A0);
    $display("wrap test done");
    wr(A_ST, 8'h37);
    wr(A_ST, 8'h07);
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    @(posedge pclk);
    for (i = 0; i < 200 && busy; i++) @(posedge pclk);
    repeat (8) @(posedge pclk);
    wr(A_ST, 8'h27);
    rdcnt(); chk(c1, 16'h000A);
    $display("external clock test done");
    wr(A_ST, 8'h30);
    wr(A_C1, 8'h04);
    lvl <= 1'b1;
    repeat (6) @(posedge pclk);
    rd(A_C1); chk(rdv[15:0], 16'h0004);
    lvl <= 1'b0;
    repeat (6) @(posedge pclk);
    wr(A_ST, 8'h00);
    lvl <= 1'b1;
    repeat (6) @(posedge pclk);
    rd(A_C1); chk(rdv[15:0], 16'h0084);
    wr(A_C1, 8'h18);
    repeat (3) @(posedge pclk);
    chk({15'h0, pin_oe}, 16'h0001);
    repeat (20) @(posedge pclk);
    chk({15'h0, pin_out}, 16'h0000);
    rd(A_C1); chk(rdv[15:0], 16'h0098);
    wr(A_C1, 8'h58);
    repeat (20) @(posedge pclk);
    chk({15'h0, chan_irq}, 16'h0001);
    $display("channel test done");
    summarize();
  end
endmodule

/* tmr_chk.sv */
// Checker for the timer core: APB answer timing and fixed read bits.
// Assumes it is bound to tmr_core and sees only its ports.
`timescale 1ns/1ps
module tmr_chk (
  input wire logic        pclk,     // Bus clock
  input wire logic        presetn,  // Async reset, active low
  input wire logic        psel,     // APB select
  input wire logic        penable,  // APB enable
  input wire logic        pwrite,   // APB direction
  input wire logic [11:0] paddr,    // APB byte address
  input wire logic [31:0] prdata,   // APB read data
  input wire logic        pready,   // APB ready
  input wire logic        pslverr,  // APB error
  input wire logic        wrap_irq  // Wrap interrupt request
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  localparam logic [11:0] A_ST = {tmr_pkg::IDX_STATUS, 2'b00};
  localparam logic [11:0] A_C1 = {tmr_pkg::IDX_CH1CTL, 2'b00};
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_READY_NEXT: assert property (psel && !penable |=> pready)
    else $error("no ready one cycle after setup");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("error without ready");
  AST_MISALIGN_ERR: assert property (psel && !penable && paddr[1:0] != 2'h0 |=> pslverr)
    else $error("misaligned access not refused");
  AST_ERR_ZERO: assert property (pslverr |-> prdata == 32'h0000_0000)
    else $error("refused access returned data");
  AST_UPPER_ZERO: assert property (pready |-> prdata[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");
  AST_CLR_READS0:
    assert property (pready && !pwrite && paddr == A_ST |-> prdata[4:3] == 2'h0)
    else $error("clear bit read as one");
  AST_CH_BIT5:
    assert property (pready && !pwrite && paddr == A_C1 |-> !prdata[5])
    else $error("channel bit 5 read as one");
  AST_HOLD: assert property (!psel |=> $stable(prdata))
    else $error("read data changed while idle");
  COV_WRITE: cover property (pready && pwrite);
  COV_ERR: cover property (pready && pslverr);
  COV_IRQ: cover property ($rose(wrap_irq));
endmodule
bind tmr_core tmr_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .prdata, .pready, .pslverr, .wrap_irq);

/* tmr_core.sv */
// Timer core: counter, wrap limit, channel one, APB register slave.
// Assumes an APB master; the channel pin is synchronous to pclk.
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps
module tmr_core (
  input  wire logic        pclk,           // Bus clock, 200 MHz
  input  wire logic        presetn,        // Async reset, active low
  input  wire logic        psel,           // APB select
  input  wire logic        penable,        // APB enable
  input  wire logic        pwrite,         // APB direction
  input  wire logic [11:0] paddr,          // APB byte address
  input  wire logic [31:0] pwdata,         // APB write data
  input  wire logic [3:0]  pstrb,          // APB byte strobes
  output logic      [31:0] prdata,         // APB read data
  output logic             pready,         // APB ready
  output logic             pslverr,        // APB error
  input  wire logic        ext_count_clock, // External count clock pin
  input  wire logic        chan_pin_in,    // Channel pin level
  output logic             chan_pin_out,   // Channel pin drive level
  output logic             chan_pin_oe,    // Channel pin drive enable
  output logic             wrap_irq,       // Wrap interrupt request
  output logic             chan_irq        // Channel interrupt request
);
  tmr_pscl_if pif ();

  logic        halt_r, halt_nxt;
  logic        clear_r, clear_nxt;
  logic [2:0]  sel_r, sel_nxt;
  logic        wflag_r, wflag_nxt;
  logic        wie_r, wie_nxt;
  logic        warm_r, warm_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic [7:0]  lat_r, lat_nxt;
  logic        lact_r, lact_nxt;
  logic [15:0] lim_r, lim_nxt;
  logic        linh_r, linh_nxt;
  logic        cflag_r, cflag_nxt;
  logic        carm_r, carm_nxt;
  logic        cie_r, cie_nxt;
  logic        msa_r, msa_nxt;
  logic [1:0]  els_r, els_nxt;
  logic        tov_r, tov_nxt;
  logic        max_r, max_nxt;
  logic [15:0] cval_r, cval_nxt;
  logic        pin1_r, pin2_r, pin3_r;
  logic        out_r, out_nxt;
  logic        oe_r, oe_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic        pready_r, pready_nxt;
  logic        perr_r, perr_nxt;
  logic        wirq_r, cirq_r;

  logic [9:0]  idx;
  logic        valid;
  logic        setup;
  logic        wr;
  logic        rd;
  logic [7:0]  wdat;
  logic [7:0]  rbyte;
  logic        reach;
  logic        ovf_set;
  logic        cap_mode;
  logic        cmp_mode;
  logic        cap;
  logic        cmp;
  logic        ch_evt;

  assign pif.clear = clear_r;
  assign pif.halt  = halt_r;
  assign pif.sel   = sel_r;

  tmr_pscl u_pscl (
    .pclk    (pclk),
    .presetn (presetn),
    .ext_pin (ext_count_clock),
    .pif     (pif)
  );

  // ----------------------------------------
  // Bus decode and read mux
  // ----------------------------------------
  always_comb begin
    idx   = paddr[11:2];
    valid = (paddr[1:0] == 2'h0) &&
            (idx == tmr_pkg::IDX_STATUS || idx == tmr_pkg::IDX_CNTH ||
             idx == tmr_pkg::IDX_CNTL   || idx == tmr_pkg::IDX_LIMH ||
             idx == tmr_pkg::IDX_LIML   || idx == tmr_pkg::IDX_CH1CTL ||
             idx == tmr_pkg::IDX_CH1VH  || idx == tmr_pkg::IDX_CH1VL);
    setup = psel & ~penable;
    wr    = psel & penable & pready_r & ~perr_r & pwrite & pstrb[0];
    rd    = psel & penable & pready_r & ~perr_r & ~pwrite;
    wdat  = pwdata[7:0];
    case (idx)
      tmr_pkg::IDX_STATUS: rbyte = {wflag_r, wie_r, halt_r, 1'b0, 1'b0, sel_r};
      tmr_pkg::IDX_CNTH:   rbyte = cnt_r[15:8];
      tmr_pkg::IDX_CNTL:   rbyte = lact_r ? lat_r : cnt_r[7:0];
      tmr_pkg::IDX_LIMH:   rbyte = lim_r[15:8];
      tmr_pkg::IDX_LIML:   rbyte = lim_r[7:0];
      tmr_pkg::IDX_CH1CTL: rbyte = {cflag_r, cie_r, 1'b0, msa_r, els_r, tov_r, max_r};
      tmr_pkg::IDX_CH1VH:  rbyte = cval_r[15:8];
      tmr_pkg::IDX_CH1VL:  rbyte = cval_r[7:0];
      default:             rbyte = 8'h00;
    endcase
    pready_nxt = setup;
    perr_nxt   = setup & ~valid;
    prdata_nxt = setup ? {24'h00_0000, (valid ? rbyte : 8'h00)} : prdata_r;
  end

  // ----------------------------------------
  // Counter, limit and wrap flag
  // ----------------------------------------
  always_comb begin
    halt_nxt  = halt_r;
    clear_nxt = 1'b0;
    sel_nxt   = sel_r;
    wflag_nxt = wflag_r;
    wie_nxt   = wie_r;
    warm_nxt  = warm_r;
    lat_nxt   = lat_r;
    lact_nxt  = lact_r;
    lim_nxt   = lim_r;
    linh_nxt  = linh_r;
    cnt_nxt   = cnt_r;
    if (clear_r) begin
      cnt_nxt = tmr_pkg::CNT_RST;
    end else if (pif.tick) begin
      cnt_nxt = (cnt_r == lim_r) ? tmr_pkg::CNT_RST : cnt_r + 16'h0001;
    end
    reach   = pif.tick & ~clear_r & (cnt_nxt == lim_r);
    ovf_set = reach & ~linh_r;
    if (rd && idx == tmr_pkg::IDX_STATUS && wflag_r) begin
      warm_nxt = 1'b1;
    end
    if (wr && idx == tmr_pkg::IDX_STATUS) begin
      if (!wdat[tmr_pkg::ST_FLAG] && warm_r) begin
        wflag_nxt = 1'b0;
      end
      warm_nxt  = 1'b0;
      wie_nxt   = wdat[tmr_pkg::ST_IE];
      halt_nxt  = wdat[tmr_pkg::ST_HALT];
      clear_nxt = wdat[tmr_pkg::ST_CLR];
      sel_nxt   = wdat[tmr_pkg::ST_SEL +: 3];
    end
    if (ovf_set) begin
      wflag_nxt = 1'b1;
      warm_nxt  = 1'b0;
    end
    if (rd && idx == tmr_pkg::IDX_CNTH && !lact_r) begin
      lat_nxt  = cnt_r[7:0];
      lact_nxt = 1'b1;
    end
    if (rd && idx == tmr_pkg::IDX_CNTL) begin
      lact_nxt = 1'b0;
    end
    if (clear_r) begin
      lat_nxt  = 8'h00;
      lact_nxt = 1'b0;
    end
    if (wr && idx == tmr_pkg::IDX_LIMH) begin
      lim_nxt[15:8] = wdat;
      linh_nxt      = 1'b1;
    end
    if (wr && idx == tmr_pkg::IDX_LIML) begin
      lim_nxt[7:0] = wdat;
      linh_nxt     = 1'b0;
    end
  end

  // ----------------------------------------
  // Channel one: capture, compare, pin
  // ----------------------------------------
  always_comb begin
    cflag_nxt = cflag_r;
    carm_nxt  = carm_r;
    cie_nxt   = cie_r;
    msa_nxt   = msa_r;
    els_nxt   = els_r;
    tov_nxt   = tov_r;
    max_nxt   = max_r;
    cval_nxt  = cval_r;
    out_nxt   = out_r;
    oe_nxt    = oe_r;
    cap_mode  = ~msa_r & (els_r != tmr_pkg::ELS_OFF);
    cmp_mode  = msa_r & (els_r != tmr_pkg::ELS_OFF);
    cap       = cap_mode & ~halt_r &
                ((els_r[0] & pin2_r & ~pin3_r) | (els_r[1] & ~pin2_r & pin3_r));
    cmp       = cmp_mode & pif.tick & ~clear_r & (cnt_nxt == cval_r);
    ch_evt    = cap | cmp;
    if (cap) begin
      cval_nxt = cnt_r;
    end
    if (rd && idx == tmr_pkg::IDX_CH1CTL && cflag_r) begin
      carm_nxt = 1'b1;
    end
    if (wr && idx == tmr_pkg::IDX_CH1CTL) begin
      if (!wdat[tmr_pkg::CH_FLAG] && carm_r) begin
        cflag_nxt = 1'b0;
      end
      carm_nxt = 1'b0;
      cie_nxt  = wdat[tmr_pkg::CH_IE];
      msa_nxt  = wdat[tmr_pkg::CH_MSA];
      els_nxt  = wdat[tmr_pkg::CH_ELS +: 2];
      tov_nxt  = wdat[tmr_pkg::CH_TOV];
      max_nxt  = wdat[tmr_pkg::CH_MAX];
    end
    if (ch_evt) begin
      cflag_nxt = 1'b1;
      carm_nxt  = 1'b0;
    end
    if (wr && idx == tmr_pkg::IDX_CH1VH) begin
      cval_nxt[15:8] = wdat;
    end
    if (wr && idx == tmr_pkg::IDX_CH1VL) begin
      cval_nxt[7:0] = wdat;
    end
    if (els_r == tmr_pkg::ELS_OFF) begin
      out_nxt = ~msa_r;
      oe_nxt  = 1'b0;
    end else if (cmp_mode) begin
      oe_nxt = 1'b1;
      if (tov_r && max_r) begin
        out_nxt = (els_r != tmr_pkg::ELS_SET);
      end else if (tov_r && reach) begin
        out_nxt = ~out_r;
      end else if (cmp) begin
        case (els_r)
          tmr_pkg::ELS_TGL: out_nxt = ~out_r;
          tmr_pkg::ELS_CLR: out_nxt = 1'b0;
          tmr_pkg::ELS_SET: out_nxt = 1'b1;
          default:          out_nxt = out_r;
        endcase
      end
    end else begin
      oe_nxt = 1'b0;
    end
  end

  // ----------------------------------------
  // State registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      halt_r   <= tmr_pkg::HALT_RST;
      clear_r  <= 1'b0;
      sel_r    <= tmr_pkg::SEL_RST;
      wflag_r  <= 1'b0;
      wie_r    <= 1'b0;
      warm_r   <= 1'b0;
      cnt_r    <= tmr_pkg::CNT_RST;
      lat_r    <= 8'h00;
      lact_r   <= 1'b0;
      lim_r    <= tmr_pkg::LIM_RST;
      linh_r   <= 1'b0;
      cflag_r  <= 1'b0;
      carm_r   <= 1'b0;
      cie_r    <= 1'b0;
      msa_r    <= 1'b0;
      els_r    <= tmr_pkg::ELS_OFF;
      tov_r    <= 1'b0;
      max_r    <= 1'b0;
      cval_r   <= tmr_pkg::CNT_RST;
      pin1_r   <= 1'b0;
      pin2_r   <= 1'b0;
      pin3_r   <= 1'b0;
      out_r    <= 1'b1;
      oe_r     <= 1'b0;
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      perr_r   <= 1'b0;
      wirq_r   <= 1'b0;
      cirq_r   <= 1'b0;
    end else begin
      halt_r   <= halt_nxt;
      clear_r  <= clear_nxt;
      sel_r    <= sel_nxt;
      wflag_r  <= wflag_nxt;
      wie_r    <= wie_nxt;
      warm_r   <= warm_nxt;
      cnt_r    <= cnt_nxt;
      lat_r    <= lat_nxt;
      lact_r   <= lact_nxt;
      lim_r    <= lim_nxt;
      linh_r   <= linh_nxt;
      cflag_r  <= cflag_nxt;
      carm_r   <= carm_nxt;
      cie_r    <= cie_nxt;
      msa_r    <= msa_nxt;
      els_r    <= els_nxt;
      tov_r    <= tov_nxt;
      max_r    <= max_nxt;
      cval_r   <= cval_nxt;
      pin1_r   <= chan_pin_in;
      pin2_r   <= pin1_r;
      pin3_r   <= pin2_r;
      out_r    <= out_nxt;
      oe_r     <= oe_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      perr_r   <= perr_nxt;
      wirq_r   <= wflag_r & wie_r;
      cirq_r   <= cflag_r & cie_r;
    end
  end

  assign prdata       = prdata_r;
  assign pready       = pready_r;
  assign pslverr      = perr_r;
  assign chan_pin_out = out_r;
  assign chan_pin_oe  = oe_r;
  assign wrap_irq     = wirq_r;
  assign chan_irq     = cirq_r;
endmodule

/* tmr_pin_model.sv */
// External count clock source and channel pin driver.
// Assumes bursts are requested only while idle; clock rests low between bursts.
`timescale 1ns/1ps
module tmr_pin_model (
  input  wire logic       pclk,     // Bus clock
  input  wire logic       go,       // Start a burst
  input  wire logic [7:0] edges,    // Rising edges in a burst
  input  wire logic       lvl,      // Channel pin level wanted
  output logic            ext_clk,  // External count clock
  output logic            pin,      // Channel pin
  output logic            busy      // Burst in progress
);
  initial begin
    ext_clk = 1'b0;
    pin = 1'b0;
    busy = 1'b0;
  end
  always @(posedge pclk) pin <= lvl;
  // Three bus cycles high and low keeps each phase above the minimum width
  always @(posedge pclk) begin
    if (go && !busy) begin
      busy <= 1'b1;
      repeat (edges) begin
        repeat (3) @(posedge pclk);
        ext_clk <= 1'b1;
        repeat (3) @(posedge pclk);
        ext_clk <= 1'b0;
      end
      busy <= 1'b0;
    end
  end
endmodule

/* tmr_pkg.sv */
// Constants shared by the timer core and its prescaler.
// Assumes an APB slave with 32-bit data; every register is one byte in the low lane.
package tmr_pkg;
  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_STATUS = 10'h040;
  localparam logic [9:0] IDX_CNTH   = 10'h041;
  localparam logic [9:0] IDX_CNTL   = 10'h042;
  localparam logic [9:0] IDX_LIMH   = 10'h043;
  localparam logic [9:0] IDX_LIML   = 10'h044;
  localparam logic [9:0] IDX_CH1CTL = 10'h048;
  localparam logic [9:0] IDX_CH1VH  = 10'h049;
  localparam logic [9:0] IDX_CH1VL  = 10'h04A;
  // Status byte fields
  localparam int ST_FLAG = 7;
  localparam int ST_IE   = 6;
  localparam int ST_HALT = 5;
  localparam int ST_CLR  = 4;
  localparam int ST_SEL  = 0;
  // Channel control byte fields
  localparam int CH_FLAG = 7;
  localparam int CH_IE   = 6;
  localparam int CH_MSA  = 4;
  localparam int CH_ELS  = 2;
  localparam int CH_TOV  = 1;
  localparam int CH_MAX  = 0;
  // Reset values and codes
  localparam logic        HALT_RST = 1'h1;
  localparam logic [2:0]  SEL_RST  = 3'h0;
  localparam logic [2:0]  SEL_EXT  = 3'h7;
  localparam logic [15:0] LIM_RST  = 16'hFFFF;
  localparam logic [15:0] CNT_RST  = 16'h0000;
  localparam logic [1:0]  ELS_OFF  = 2'h0;
  localparam logic [1:0]  ELS_TGL  = 2'h1;
  localparam logic [1:0]  ELS_CLR  = 2'h2;
  localparam logic [1:0]  ELS_SET  = 2'h3;
  localparam logic [5:0]  PSC_RST  = 6'h00;
endpackage

/* tmr_pscl.sv */
// Prescaler: divides the bus clock or follows the external count pin.
// Assumes the external pin is slower than half the bus clock.
`timescale 1ns/1ps
module tmr_pscl (
  input  wire logic pclk,     // Bus clock
  input  wire logic presetn,  // Async reset, active low
  input  wire logic ext_pin,  // External count clock pin
  tmr_pscl_if.pscl  pif       // Control from the core
);
  logic [5:0] psc_r;
  logic [5:0] psc_nxt;
  logic [5:0] mask;
  logic       sync1_r;
  logic       sync2_r;
  logic       sync3_r;

  // ----------------------------------------
  // Divider and pin edge
  // ----------------------------------------
  always_comb begin
    mask = 6'(({6'h00, 1'b1} << pif.sel) - 7'h01);
    if (pif.clear) begin
      psc_nxt = tmr_pkg::PSC_RST;
    end else if (pif.halt) begin
      psc_nxt = psc_r;
    end else begin
      psc_nxt = psc_r + 6'h01;
    end
    if (pif.halt || pif.clear) begin
      pif.tick = 1'b0;
    end else if (pif.sel == tmr_pkg::SEL_EXT) begin
      pif.tick = sync2_r & ~sync3_r;
    end else begin
      pif.tick = ((psc_r & mask) == mask);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      psc_r   <= tmr_pkg::PSC_RST;
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      sync3_r <= 1'b0;
    end else begin
      psc_r   <= psc_nxt;
      sync1_r <= ext_pin;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end
endmodule

/* tmr_pscl_if.sv */
// Interface between the timer core and its prescaler.
// Assumes both ends run on the same bus clock.
`timescale 1ns/1ps
interface tmr_pscl_if;
  logic       tick;   // One counter clock this cycle
  logic       clear;  // Zero the prescaler
  logic       halt;   // Freeze the prescaler
  logic [2:0] sel;    // Divider select code
  modport core (output clear, output halt, output sel, input tick);
  modport pscl (input clear, input halt, input sel, output tick);
endinterface
